/* logic/tcrb_core.sv */
`timescale 1ns/1ps
`include "tcrb_consts.svh"
module tcrb_core #(
  parameter int MACHINE_DIV = `TCRB_MACHINE_DIV,
  parameter int STATE_DIV   = `TCRB_STATE_DIV
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CTRL_WR,
  input  wire logic [7:0]  CTRL_WDATA,
  input  wire logic        MODE_WR,
  input  wire logic [1:0]  MODE_WDATA,
  input  wire logic        CNT_WR,
  input  wire logic [15:0] CNT_WDATA,
  input  wire logic        RELOAD_WR,
  input  wire logic [15:0] RELOAD_WDATA,
  input  wire logic        EXT_COUNT_INPUT,
  input  wire logic        TRIGGER_INPUT,
  output logic [7:0]       CTRL_RDATA,
  output logic [1:0]       MODE_RDATA,
  output logic [15:0]      COUNT,
  output logic [15:0]      RELOAD_CAPTURE,
  output logic             CLOCK_OUT_PIN,
  output logic             CLOCK_OUT_OE,
  output logic             TX_BAUD_TICK,
  output logic             RX_BAUD_TICK,
  output logic             TIMER_IRQ
);

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (MACHINE_DIV < 2 || STATE_DIV < 2) begin : g_bad_div
      $error("tcrb_core: dividers must be at least 2");
    end
  endgenerate

  // ****************************************
  // Rate enables
  // ****************************************
  logic machine_tick;
  logic state_tick;

  tcrb_div #(.DIV(MACHINE_DIV)) u_machine_div (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (machine_tick)
  );

  tcrb_div #(.DIV(STATE_DIV)) u_state_div (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (state_tick)
  );

  // ****************************************
  // State
  // ****************************************
  tcrb_pkg::tcrb_state_t s_r;
  tcrb_pkg::tcrb_state_t s_nxt;

  tcrb_pkg::tcrb_mode_t  mode;
  logic                  run;
  logic                  tx_sel;
  logic                  rx_sel;
  logic                  ext_en;
  logic                  src_ext;
  logic                  cap_sel;
  logic                  clk_oe;
  logic                  down_count_enable;
  logic                  pin_fall;
  logic                  trig_fall;
  logic                  trig_level;
  logic                  step;
  logic                  roll;
  logic                  ovf_set;
  logic                  ext_set;
  logic                  ext_tog;
  logic                  ext_base;
  logic                  ovf_base;
  logic                  ext_quiet;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    // ****************************************
    // Defaults and field decode
    // ****************************************
    s_nxt      = s_r;
    run        = s_r.ctl[`TCRB_CTL_RUN];
    tx_sel     = s_r.ctl[`TCRB_CTL_TXSEL];
    rx_sel     = s_r.ctl[`TCRB_CTL_RXSEL];
    ext_en     = s_r.ctl[`TCRB_CTL_EXTEN];
    src_ext    = s_r.ctl[`TCRB_CTL_SRC];
    cap_sel    = s_r.ctl[`TCRB_CTL_CAPSEL];
    clk_oe     = s_r.mdr[`TCRB_MOD_CLKOE];
    down_count_enable       = s_r.mdr[`TCRB_MOD_DOWN_COUNT_ENABLE];
    roll       = 1'b0;
    ext_set    = 1'b0;
    ext_tog    = 1'b0;

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    s_nxt.cnt_pin_s = {s_r.cnt_pin_s[1:0], EXT_COUNT_INPUT};
    s_nxt.trig_s    = {s_r.trig_s[1:0], TRIGGER_INPUT};
    pin_fall        = s_r.cnt_pin_s[2] & ~s_r.cnt_pin_s[1];
    trig_fall       = s_r.trig_s[2] & ~s_r.trig_s[1];
    trig_level      = s_r.trig_s[1];

    // ****************************************
    // Mode decode
    // ****************************************
    if (!run) begin
      mode = tcrb_pkg::TCRB_OFF;
    end else if (tx_sel || rx_sel) begin
      mode = tcrb_pkg::TCRB_BAUD;
    end else if (cap_sel) begin
      mode = tcrb_pkg::TCRB_CAPTURE;
    end else begin
      mode = tcrb_pkg::TCRB_RELOAD;
    end

    // ****************************************
    // Count source and rate
    // ****************************************
    if (src_ext) begin
      step = pin_fall;
    end else if (mode == tcrb_pkg::TCRB_BAUD) begin
      step = state_tick;
    end else begin
      step = machine_tick;
    end

    // ****************************************
    // Counter
    // ****************************************
    unique case (mode)
      tcrb_pkg::TCRB_OFF: begin
      end
      tcrb_pkg::TCRB_CAPTURE: begin
        if (step) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
          roll      = (s_r.cnt == `TCRB_ALL_ONES);
        end
        if (ext_en && trig_fall) begin
          s_nxt.rcap = s_r.cnt;
          ext_set    = 1'b1;
        end
      end
      tcrb_pkg::TCRB_RELOAD: begin
        if (down_count_enable) begin
          if (step && trig_level) begin
            if (s_r.cnt == `TCRB_ALL_ONES) begin
              s_nxt.cnt = s_r.rcap;
              roll      = 1'b1;
              ext_tog   = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end else if (step) begin
            if (s_r.cnt == s_r.rcap) begin
              s_nxt.cnt = `TCRB_ALL_ONES;
              roll      = 1'b1;
              ext_tog   = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end else begin
          if (step) begin
            if (s_r.cnt == `TCRB_ALL_ONES) begin
              s_nxt.cnt = s_r.rcap;
              roll      = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end
          if (ext_en && trig_fall) begin
            s_nxt.cnt = s_r.rcap;
            ext_set   = 1'b1;
          end
        end
      end
      tcrb_pkg::TCRB_BAUD: begin
        if (step) begin
          if (s_r.cnt == `TCRB_ALL_ONES) begin
            s_nxt.cnt = s_r.rcap;
            roll      = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        if (ext_en && trig_fall) begin
          ext_set = 1'b1;
        end
      end
    endcase

    // ****************************************
    // Overflow flag cause
    // ****************************************
    ovf_set = roll && (mode != tcrb_pkg::TCRB_BAUD) && !clk_oe;

    // ****************************************
    // Clock-out toggles on each rollover, shared with baud
    // ****************************************
    s_nxt.clk_oe = clk_oe;
    if (!clk_oe) begin
      s_nxt.clk_out = 1'b0;
    end else if (roll) begin
      s_nxt.clk_out = ~s_r.clk_out;
    end

    // ****************************************
    // Baud tick every 16 rollovers
    // ****************************************
    s_nxt.tx_tick = 1'b0;
    s_nxt.rx_tick = 1'b0;
    if (mode != tcrb_pkg::TCRB_BAUD) begin
      s_nxt.baud_div = 4'h0;
    end else if (roll) begin
      s_nxt.baud_div = s_r.baud_div + 4'h1;
      if (s_r.baud_div == `TCRB_BAUD_LAST) begin
        s_nxt.tx_tick = tx_sel;
        s_nxt.rx_tick = rx_sel;
      end
    end

    // ****************************************
    // Software writes; hardware flag events win
    // ****************************************
    ovf_base = s_r.ctl[`TCRB_CTL_OVF];
    ext_base = s_r.ctl[`TCRB_CTL_EXT];
    if (CTRL_WR) begin
      s_nxt.ctl = CTRL_WDATA;
      ovf_base  = CTRL_WDATA[`TCRB_CTL_OVF];
      ext_base  = CTRL_WDATA[`TCRB_CTL_EXT];
    end
    s_nxt.ctl[`TCRB_CTL_OVF] = ovf_base | ovf_set;
    if (ext_tog) begin
      s_nxt.ctl[`TCRB_CTL_EXT] = ~s_r.ctl[`TCRB_CTL_EXT];
    end else begin
      s_nxt.ctl[`TCRB_CTL_EXT] = ext_base | ext_set;
    end

    // ****************************************
    // Mode, count and reload writes
    // ****************************************
    if (MODE_WR) begin
      s_nxt.mdr = MODE_WDATA;
    end
    if (CNT_WR) begin
      s_nxt.cnt = CNT_WDATA;
    end
    if (RELOAD_WR) begin
      s_nxt.rcap = RELOAD_WDATA;
    end

    // ****************************************
    // Shared interrupt request
    // ****************************************
    // Down-count reload keeps the external flag off the request
    ext_quiet = s_nxt.mdr[`TCRB_MOD_DOWN_COUNT_ENABLE]
              & s_nxt.ctl[`TCRB_CTL_RUN]
              & ~s_nxt.ctl[`TCRB_CTL_TXSEL]
              & ~s_nxt.ctl[`TCRB_CTL_RXSEL]
              & ~s_nxt.ctl[`TCRB_CTL_CAPSEL];

    s_nxt.irq = s_nxt.ctl[`TCRB_CTL_OVF]
              | (s_nxt.ctl[`TCRB_CTL_EXT] & ~ext_quiet);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_r          <= '0;
      s_r.ctl      <= `TCRB_CTL_RST;
      s_r.mdr      <= `TCRB_MOD_RST;
      s_r.cnt      <= `TCRB_CNT_RST;
      s_r.rcap     <= `TCRB_CNT_RST;
    end else begin
      s_r          <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CTRL_RDATA     = s_r.ctl;
  assign MODE_RDATA     = s_r.mdr;
  assign COUNT          = s_r.cnt;
  assign RELOAD_CAPTURE = s_r.rcap;
  assign CLOCK_OUT_PIN  = s_r.clk_out;
  assign CLOCK_OUT_OE   = s_r.clk_oe;
  assign TX_BAUD_TICK   = s_r.tx_tick;
  assign RX_BAUD_TICK   = s_r.rx_tick;
  assign TIMER_IRQ      = s_r.irq;
endmodule

/* logic/tcrb_consts.svh */
`ifndef TCRB_CONSTS_SVH
`define TCRB_CONSTS_SVH
// Behaviour
// - Clock-out drives 50% square wave when enabled
// - Clock-out rollovers raise no timer interrupt
// - Baud and clock-out share one rollover
// - 16-bit counter, internal or external source
// - Mode decode: off, baud, capture, reload
// - Capture mode overflow sets overflow flag
// - Trigger falling edge captures count, sets flag
// - Capture keeps counting; flags share one request
// - Down-count enable resets to zero
// - Up reload: all-ones overflow reloads, sets flag
// - Trigger edge forces reload, sets external flag
// - Trigger level picks direction when down-count enabled
// - Down underflow at reload value loads all-ones
// - External flag toggles, no request, when down-enabled
// - Transmit and receive baud selects act independently
// - Baud rollover reloads from reload pair
// - Timer step osc/12, baud step osc/2
// - Baud tick is overflow rate over 16
// - Baud rollover sets no flag, no request
// - Baud trigger edge sets flag, no reload
// - Mode register: clock-out bit 1, down bit 0

// Control register bit positions
`define TCRB_CTL_OVF     7
`define TCRB_CTL_EXT     6
`define TCRB_CTL_RXSEL   5
`define TCRB_CTL_TXSEL   4
`define TCRB_CTL_EXTEN   3
`define TCRB_CTL_RUN     2
`define TCRB_CTL_SRC     1
`define TCRB_CTL_CAPSEL  0
// Mode register bit positions
`define TCRB_MOD_CLKOE   1
`define TCRB_MOD_DOWN_COUNT_ENABLE    0
// Reset values
`define TCRB_CTL_RST     8'h00
`define TCRB_MOD_RST     2'h0
`define TCRB_CNT_RST     16'h0000
// Counter values
`define TCRB_ALL_ONES    16'hFFFF
// Clock dividers in oscillator cycles; last baud rollover count
`define TCRB_MACHINE_DIV 12
`define TCRB_STATE_DIV   2
`define TCRB_BAUD_LAST   4'hF
`endif

/* logic/tcrb_pkg.sv */
package tcrb_pkg;

  typedef enum logic [1:0] {TCRB_OFF, TCRB_CAPTURE, TCRB_RELOAD, TCRB_BAUD} tcrb_mode_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [1:0]  mdr;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [2:0]  cnt_pin_s;
    logic [2:0]  trig_s;
    logic        clk_out;
    logic        clk_oe;
    logic [3:0]  baud_div;
    logic        tx_tick;
    logic        rx_tick;
    logic        irq;
  } tcrb_state_t;

endpackage

/* logic/tcrb_div.sv */
`timescale 1ns/1ps
module tcrb_div #(
  parameter int DIV = 12
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = (DIV < 2) ? 1 : $clog2(DIV);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tcrb_div_state_t;

  tcrb_div_state_t s_r;
  tcrb_div_state_t s_nxt;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("tcrb_div: DIV must be at least 2");
    end
  endgenerate

  // ****************************************
  // One-cycle enable every DIV clocks
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt == W'(DIV - 1)) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt  = s_r.cnt + W'(1);
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

/* verif/tcrb_checker.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module tcrb_checker #(
  parameter int MACHINE_DIV = 12
) (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        CTRL_WR,
  input wire logic        CNT_WR,
  input wire logic [7:0]  CTRL_RDATA,
  input wire logic [1:0]  MODE_RDATA,
  input wire logic [15:0] COUNT,
  input wire logic [15:0] RELOAD_CAPTURE,
  input wire logic        CLOCK_OUT_PIN,
  input wire logic        CLOCK_OUT_OE,
  input wire logic        TX_BAUD_TICK,
  input wire logic        RX_BAUD_TICK,
  input wire logic        TIMER_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [15:0] prev_r;
  logic [7:0]  gap_r;
  logic        quiet_r;
  logic        qrun_r;
  wire         quiet = CTRL_RDATA[2] && CTRL_RDATA[5:3] == 3'h0 && !CTRL_RDATA[1]
                       && !CTRL_WR && !CNT_WR;
  wire         moved = COUNT != prev_r;
  // Gap between internal timer steps
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prev_r <= 16'h0000;
      gap_r <= 8'h00;
      quiet_r <= 1'b0;
      qrun_r <= 1'b0;
    end else begin
      prev_r <= COUNT;
      gap_r <= moved ? 8'h00 : gap_r + 8'h01;
      quiet_r <= quiet;
      qrun_r <= quiet && (qrun_r || (moved && quiet_r));
    end
  end
  sequence s_step;
    moved && qrun_r;
  endsequence
  sequence s_tx_idle;
    !CTRL_RDATA[4] ##1 !CTRL_RDATA[4];
  endsequence
  a_step_spacing: assert property (s_step |-> gap_r == 8'(MACHINE_DIV - 1))
    else $error("timer step spacing wrong");
  a_off_hold: assert property (!CTRL_RDATA[2] && !CNT_WR |=> $stable(COUNT))
    else $error("counter moved while stopped");
  a_up_reload: assert property ($rose(CTRL_RDATA[7]) && !$past(CTRL_WR) && CTRL_RDATA[2]
    && CTRL_RDATA[5:4] == 2'h0 && !CTRL_RDATA[0] && MODE_RDATA == 2'h0
    |-> COUNT == RELOAD_CAPTURE && $past(COUNT) == 16'hFFFF)
    else $error("overflow without reload");
  a_capture_copy: assert property ($rose(CTRL_RDATA[6]) && !$past(CTRL_WR)
    && CTRL_RDATA[0] && CTRL_RDATA[5:4] == 2'h0 |-> RELOAD_CAPTURE == $past(COUNT))
    else $error("capture value wrong");
  a_clkout_quiet: assert property (MODE_RDATA[1] && !CTRL_RDATA[7] && !CTRL_WR
    |=> !CTRL_RDATA[7])
    else $error("overflow flag set in clock-out");
  a_baud_quiet: assert property (CTRL_RDATA[5:4] != 2'h0 && !CTRL_RDATA[7] && !CTRL_WR
    |=> !CTRL_RDATA[7])
    else $error("overflow flag set in baud mode");
  a_tx_gated: assert property (s_tx_idle |-> !TX_BAUD_TICK)
    else $error("transmit tick while deselected");
  a_rx_gated: assert property (!CTRL_RDATA[5] [*2] |-> !RX_BAUD_TICK)
    else $error("receive tick while deselected");
  a_tick_pulse: assert property (TX_BAUD_TICK || RX_BAUD_TICK
    |=> !TX_BAUD_TICK && !RX_BAUD_TICK)
    else $error("baud tick too long");
  a_irq_flag: assert property (CTRL_RDATA[7] |-> TIMER_IRQ)
    else $error("overflow flag without request");
  a_irq_idle: assert property (CTRL_RDATA[7:6] == 2'h0 |-> !TIMER_IRQ)
    else $error("request without flag");
  a_pin_idle: assert property (!MODE_RDATA[1] [*2] |-> !CLOCK_OUT_PIN && !CLOCK_OUT_OE)
    else $error("clock-out pin driven while disabled");
endmodule

bind tcrb_core tcrb_checker #(.MACHINE_DIV(MACHINE_DIV)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .CTRL_WR(CTRL_WR), .CNT_WR(CNT_WR),
  .CTRL_RDATA(CTRL_RDATA), .MODE_RDATA(MODE_RDATA), .COUNT(COUNT),
  .RELOAD_CAPTURE(RELOAD_CAPTURE), .CLOCK_OUT_PIN(CLOCK_OUT_PIN),
  .CLOCK_OUT_OE(CLOCK_OUT_OE), .TX_BAUD_TICK(TX_BAUD_TICK),
  .RX_BAUD_TICK(RX_BAUD_TICK), .TIMER_IRQ(TIMER_IRQ)
);

/* verif/tcrb_pins.sv */
`timescale 1ns/1ps
// ****
// Board pins
// ****
module tcrb_pins (
  input  wire logic clk,
  output logic      cnt_pin,
  output logic      trig_pin
);
  // Pins idle high
  initial begin
    cnt_pin = 1'b1;
    trig_pin = 1'b1;
  end
  task automatic set_dir(input logic v);
    @(negedge clk);
    trig_pin = v;
  endtask
  task automatic fall_trig();
    @(negedge clk);
    trig_pin = 1'b0;
    repeat (4) @(negedge clk);
    trig_pin = 1'b1;
  endtask
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      cnt_pin = 1'b0;
      repeat (3) @(negedge clk);
      cnt_pin = 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
// ****
// Bench
// ****
module testbench;
  typedef struct {
    logic [1:0] md; logic [7:0] ctl; logic [15:0] cnt; logic [15:0] rld;
    logic trg; logic fal; int edg; int k;
    logic [15:0] ecnt; logic [7:0] ectl; logic [15:0] erld;
  } tcrb_row_t;
  tcrb_row_t   rows [11] = '{
    '{2'h0, 8'h00, 16'h1111, 16'h2222, 1'b1, 1'b0, 0, 8, 16'h1111, 8'h00, 16'h2222},
    '{2'h0, 8'h04, 16'hFFFE, 16'h1234, 1'b1, 1'b0, 0, 12, 16'h1235, 8'h80, 16'h1234},
    '{2'h0, 8'h05, 16'hFFFF, 16'h1234, 1'b1, 1'b0, 0, 8, 16'h0001, 8'h81, 16'h1234},
    '{2'h0, 8'h14, 16'hFFFE, 16'hFFF0, 1'b1, 1'b0, 0, 8, 16'hFFF2, 8'h10, 16'hFFF0},
    '{2'h2, 8'h04, 16'hFFFF, 16'hFFFE, 1'b1, 1'b0, 0, 12, 16'hFFFE, 8'h00, 16'hFFFE},
    '{2'h1, 8'h04, 16'h0002, 16'h0001, 1'b0, 1'b0, 0, 12, 16'hFFFE, 8'hC0, 16'h0001},
    '{2'h1, 8'h04, 16'hFFFF, 16'h0100, 1'b1, 1'b0, 0, 4, 16'h0100, 8'hC0, 16'h0100},
    '{2'h0, 8'h0F, 16'h0100, 16'h1234, 1'b1, 1'b1, 0, 8, 16'h0100, 8'h4B, 16'h0100},
    '{2'h0, 8'h0E, 16'h0100, 16'h4321, 1'b1, 1'b1, 0, 8, 16'h4321, 8'h4A, 16'h4321},
    '{2'h0, 8'h1E, 16'h0100, 16'h4321, 1'b1, 1'b1, 0, 8, 16'h0100, 8'h5A, 16'h4321},
    '{2'h0, 8'h06, 16'hFFFD, 16'h0005, 1'b1, 1'b0, 5, 8, 16'h0007, 8'h82, 16'h0005}};
  tcrb_row_t   r;
  logic        clk, rst, ctrl_wr, mode_wr, cnt_wr, rld_wr, ext_pin, trig_pin;
  logic [7:0]  ctrl_wd, ctrl_rd, sel;
  logic [1:0]  mode_wd, mode_rd;
  logic [15:0] cnt_wd, rld_wd, count, rcap;
  logic        pin, oe, txt, rxt, irq, pin_q, counting;
  int          fail_count, samples_checked, tx_n, rx_n, tog_n;

  tcrb_core #(.MACHINE_DIV(4), .STATE_DIV(2)) u_dut (
    .CLK_SYS(clk), .RST(rst), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wd),
    .MODE_WR(mode_wr), .MODE_WDATA(mode_wd), .CNT_WR(cnt_wr), .CNT_WDATA(cnt_wd),
    .RELOAD_WR(rld_wr), .RELOAD_WDATA(rld_wd), .EXT_COUNT_INPUT(ext_pin),
    .TRIGGER_INPUT(trig_pin), .CTRL_RDATA(ctrl_rd), .MODE_RDATA(mode_rd), .COUNT(count),
    .RELOAD_CAPTURE(rcap), .CLOCK_OUT_PIN(pin), .CLOCK_OUT_OE(oe), .TX_BAUD_TICK(txt),
    .RX_BAUD_TICK(rxt), .TIMER_IRQ(irq));
  tcrb_pins u_pins (.clk(clk), .cnt_pin(ext_pin), .trig_pin(trig_pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Tick and toggle counters
  always @(negedge clk) begin
    if (counting) begin
      tx_n += txt;
      rx_n += rxt;
      tog_n += (pin !== pin_q);
    end
    pin_q = pin;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // Write: 0 control, 1 mode, 2 count, 3 reload
  task automatic wr(input int s, input logic [15:0] d);
    ctrl_wd = d[7:0];
    mode_wd = d[1:0];
    cnt_wd = d;
    rld_wd = d;
    ctrl_wr = (s == 0);
    mode_wr = (s == 1);
    cnt_wr = (s == 2);
    rld_wr = (s == 3);
    @(negedge clk);
    {ctrl_wr, mode_wr, cnt_wr, rld_wr} = 4'h0;
    @(negedge clk);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {ctrl_wr, mode_wr, cnt_wr, rld_wr, counting} = 5'h00;
    {ctrl_wd, mode_wd, cnt_wd, rld_wd} = 42'h000_0000_0000;
    {fail_count, samples_checked, tx_n, rx_n, tog_n} = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("ctrl", 16'h0000, {8'h00, ctrl_rd});
    chk("mode", 16'h0000, {14'h0000, mode_rd});
    foreach (rows[i]) begin
      r = rows[i];
      u_pins.set_dir(r.trg);
      wr(1, {14'h0000, r.md});
      wr(2, r.cnt);
      wr(3, r.rld);
      wr(0, {8'h00, r.ctl});
      if (r.fal) u_pins.fall_trig();
      if (r.edg > 0) u_pins.pulses(r.edg);
      repeat (r.k - 2) @(negedge clk);
      wr(0, {8'h00, ctrl_rd & 8'hFB});
      chk("count", r.ecnt, count);
      chk("ctrl", {8'h00, r.ectl}, {8'h00, ctrl_rd});
      chk("reload", r.erld, rcap);
      if (!r.md[0]) chk("irq", {15'h0000, |r.ectl[7:6]}, {15'h0000, irq});
    end
    // Baud ticks and clock-out together
    for (int j = 0; j < 2; j++) begin
      sel = j ? 8'h24 : 8'h34;
      wr(1, 16'h0002);
      wr(2, 16'hFFFF);
      wr(3, 16'hFFFF);
      {tx_n, rx_n, tog_n} = '0;
      counting = 1'b1;
      wr(0, {8'h00, sel});
      chk("oe", 16'h0001, {15'h0000, oe});
      repeat (62) @(negedge clk);
      wr(0, 16'h0000);
      repeat (4) @(negedge clk);
      counting = 1'b0;
      chk("tx ticks", sel[4] ? 16'h0002 : 16'h0000, 16'(tx_n));
      chk("rx ticks", sel[5] ? 16'h0002 : 16'h0000, 16'(rx_n));
      chk("toggles", 16'h0020, 16'(tog_n));
    end
    // Reset in mid-run
    wr(1, 16'h0003);
    wr(0, 16'h0004);
    repeat (5) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("mode", 16'h0000, {14'h0000, mode_rd});
    chk("count", 16'h0000, count);
    rst = 1'b0;
    @(negedge clk);
    chk("ctrl", 16'h0000, {8'h00, ctrl_rd});
    stop_test();
  end
endmodule
